// ---- core/adc_link_pkg.sv ----
// Shared constants and types for the serial converter link
`default_nettype none

package adc_link_pkg;

    // Frame layout
    localparam int RESULT_W        = 16;
    localparam int LEAD_ZEROS      = 8;
    localparam int FRAME_BITS      = LEAD_ZEROS + RESULT_W;
    localparam int GROUP_BITS      = 8;
    localparam int CNT_W           = 5;
    localparam int IDX_W           = 4;
    localparam int WAIT_W          = 4;

    // Falling-edge numbers counted from the chip select falling edge
    localparam int HOLD_FALL       = 6;
    localparam int FIRST_DATA_FALL = LEAD_ZEROS;
    localparam int LAST_DATA_FALL  = FIRST_DATA_FALL + RESULT_W - 1;
    localparam int TRAIL_FALL      = FRAME_BITS;

    // Counter values seen just before (first three) or just after (last three) the numbered falling edge
    localparam logic [CNT_W-1:0] HOLD_EDGE  = CNT_W'(HOLD_FALL - 1);
    localparam logic [CNT_W-1:0] FIRST_EDGE = CNT_W'(FIRST_DATA_FALL - 1);
    localparam logic [CNT_W-1:0] LAST_EDGE  = CNT_W'(LAST_DATA_FALL - 1);
    localparam logic [CNT_W-1:0] CNT_SAT    = CNT_W'(TRAIL_FALL);
    localparam logic [CNT_W-1:0] FRAME_CNT  = CNT_W'(FRAME_BITS);
    localparam logic [CNT_W-1:0] GROUP_CNT  = CNT_W'(GROUP_BITS);

    // Host timing, system clock 10 MHz
    localparam int CLK_PERIOD_NS   = 100;
    localparam int CS_HIGH_MIN_NS  = 50;
    localparam int CS_SETUP_NS     = 100;
    localparam int SCLK_HALF_NS    = 200;
    localparam int GROUP_GAP_NS    = 400;

    // Least times round up to whole cycles
    localparam int CS_HIGH_CYC   = (CS_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_SETUP_CYC  = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GROUP_GAP_CYC = (GROUP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [WAIT_W-1:0] CS_HIGH_LOAD  = WAIT_W'(CS_HIGH_CYC - 1);
    localparam logic [WAIT_W-1:0] CS_SETUP_LOAD = WAIT_W'(CS_SETUP_CYC - 1);
    localparam logic [WAIT_W-1:0] HALF_LAST     = WAIT_W'(SCLK_HALF_CYC - 1);
    localparam logic [WAIT_W-1:0] GAP_LOAD      = WAIT_W'(GROUP_GAP_CYC - 1);

    typedef enum logic [2:0] {
        H_IDLE   = 3'h0,
        H_SETUP  = 3'h1,
        H_RUN    = 3'h2,
        H_GAP    = 3'h3,
        H_CSHIGH = 3'h4
    } host_state_t;

endpackage

`default_nettype wire

// ---- core/adc_link_if.sv ----
// Three-wire link between the converter and its serial master
`default_nettype none

interface adc_link_if;
    logic cs_b;
    logic sclk;
    logic dout;
    logic dout_oe;
    logic dout_line;

    // Data line resolved here, never inside the ends. A released line
    // shows the inverse of dout, which deselect holds at zero, so a late sample reads one.
    assign dout_line = dout_oe ? dout : ~dout;

    modport device (
        input  cs_b,
        input  sclk,
        output dout,
        output dout_oe
    );

    modport host (
        output cs_b,
        output sclk,
        input  dout_line
    );
endinterface

`default_nettype wire

// ---- core/adc_serial_device.sv ----
// Converter end: acquisition, bit stepping and shift-out on the serial clock
`default_nettype none
// Behaviour
// (RQ1) Chip select low powers up, drives output low
// (RQ2) Conversion steps on serial clock after sixth cycle
// (RQ3) Sample frozen at sixth falling edge
// (RQ4) Result MSB first after eighth fall, zeros before
// (RQ5) Twenty-four falls: eight zeros, sixteen bits
// (RQ6) Extra clocks give zeros, leave converter alone
// (RQ7) Chip select high resets, powers down, floats output
// (RQ8) Chip select high mid-conversion aborts at once
// (RQ9) Device shifts on fall, host captures on rise
// (RQ10) Host gives 24 clocks, raises select after 24th fall
// (RQ11) Host holds select high at least 50 ns
// (RQ12) Host clock between 100 kHz and 4.8 MHz
// (RQ13) Host clock duty 40-60%, phases at least 65 ns
// (RQ14) Host clock idles low, phase zero
// (RQ15) Byte reads: zeros, MSB to bit eight, seven to LSB
// (RQ16) Byte groups or continuous burst give same bits
// (RQ17) Result is straight binary, one step per code
// (RQ18) Early select rise discards partial result

module adc_serial_device (
    input  wire logic                          clk_i,
    input  wire logic                          rst_b_i,
    adc_link_if.device                         link,
    input  wire logic [adc_link_pkg::RESULT_W-1:0] analog_input_i,
    output logic                               powered_o,
    output logic                               converting_o,
    output logic [adc_link_pkg::RESULT_W-1:0]  result_o,
    output logic                               result_valid_o
);
    import adc_link_pkg::*;

    // ------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------

    logic                 link_rst_b;
    logic [CNT_W-1:0]     fall_cnt_q;
    logic [CNT_W-1:0]     fall_cnt_d;
    logic [RESULT_W-1:0]  held_q;
    logic [RESULT_W-1:0]  sar_q;
    logic [RESULT_W-1:0]  sar_d;
    logic                 dout_q;
    logic                 dout_d;
    logic                 conv_q;
    logic [RESULT_W-1:0]  word_q;
    logic                 done_tgl_q;
    logic [RESULT_W-1:0]  track_meta_q;
    logic [RESULT_W-1:0]  track_sync_q;

    logic                 hold_edge;
    logic                 data_edge;
    logic                 last_edge;
    logic                 trailing;
    logic [IDX_W-1:0]     bit_idx;
    logic [RESULT_W-1:0]  bit_mask;
    logic [RESULT_W-1:0]  trial;
    logic                 keep;

    // Chip select high holds every interface register but word_q and done_tgl_q in reset, so
    // raising it at any point aborts and forgets the frame.
    assign link_rst_b = rst_b_i & ~link.cs_b; // RQ7 RQ8 RQ18

    // Output floats whenever the part is deselected.
    assign link.dout_oe = ~link.cs_b; // RQ1 RQ7
    assign link.dout    = dout_q;

    // Edge decode: fall_cnt_q holds the number of falls seen so far,
    // so the edge now arriving is fall_cnt_q + 1.
    assign hold_edge = (fall_cnt_q == HOLD_EDGE); // RQ3
    assign data_edge = (fall_cnt_q >= FIRST_EDGE) && (fall_cnt_q <= LAST_EDGE); // RQ4
    assign last_edge = (fall_cnt_q == LAST_EDGE); // RQ5
    assign trailing  = (fall_cnt_q >= CNT_SAT);

    // The counter stops once the frame is out; trailing clocks then
    // change only the input synchroniser flops and keep the line at zero.
    assign fall_cnt_d = trailing ? fall_cnt_q : fall_cnt_q + CNT_W'(1); // RQ6

    // Bit index counts down from MSB on the eighth fall to LSB on the 23rd
    assign bit_idx  = IDX_W'(LAST_EDGE - fall_cnt_q); // RQ4
    assign bit_mask = RESULT_W'(1) << bit_idx;

    // One successive-approximation step per data edge: try the bit,
    // keep it if the trial code does not exceed the held sample. The
    // held sample is already a code, so the decisions reproduce it
    // exactly as unipolar straight binary.
    assign trial = sar_q | bit_mask; // RQ2
    assign keep  = (trial <= held_q); // RQ17
    assign sar_d = (data_edge && keep) ? trial : sar_q;

    // Leading zeros up to the eighth fall, result bits, then zeros.
    // The same stream serves byte groups and one burst alike, since
    // only clock edges advance it and idle clock time does nothing.
    assign dout_d = data_edge ? keep : 1'h0; // RQ4 RQ6 RQ16

    // Frame logic: all changes on the falling edge of the link clock.
    // The input word comes from the system side, so it passes two link
    // clock flops before the hold reads it; the hold therefore takes the
    // word as it stood at the fourth fall.
    always_ff @(negedge link.sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            fall_cnt_q <= '0;
            held_q     <= '0;
            sar_q      <= '0;
            dout_q     <= 1'h0; // RQ1
            conv_q     <= 1'h0;
            track_meta_q <= '0;
            track_sync_q <= '0;
        end else begin
            fall_cnt_q <= fall_cnt_d;
            track_meta_q <= analog_input_i;
            track_sync_q <= track_meta_q;
            sar_q      <= sar_d; // RQ2
            dout_q     <= dout_d; // RQ9
            if (hold_edge) begin
                held_q <= track_sync_q; // RQ3
            end
            if (hold_edge) begin
                conv_q <= 1'h1; // RQ2
            end else if (last_edge) begin
                conv_q <= 1'h0;
            end
        end
    end

    // Completed word and its event toggle survive chip select, so the
    // system side can collect them after the host has deselected. Only
    // a frame that reaches its last bit updates them.
    always_ff @(negedge link.sclk or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_q     <= '0;
            done_tgl_q <= 1'h0;
        end else if (link_rst_b && last_edge) begin
            word_q     <= sar_d; // RQ18
            done_tgl_q <= ~done_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // System clock domain
    // ------------------------------------------------------------

    logic                 cs_meta_q;
    logic                 cs_sync_q;
    logic                 conv_meta_q;
    logic                 conv_sync_q;
    logic                 tgl_meta_q;
    logic                 tgl_sync_q;
    logic                 tgl_seen_q;
    logic                 done_evt;
    logic [RESULT_W-1:0]  result_q;
    logic                 valid_q;

    assign done_evt = tgl_sync_q ^ tgl_seen_q;

    // Level synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_meta_q   <= 1'h1;
            cs_sync_q   <= 1'h1;
            conv_meta_q <= 1'h0;
            conv_sync_q <= 1'h0;
        end else begin
            cs_meta_q   <= link.cs_b;
            cs_sync_q   <= cs_meta_q;
            conv_meta_q <= conv_q;
            conv_sync_q <= conv_meta_q;
        end
    end

    // Toggle crossing for the completion event. The word itself is
    // stable for at least 23 link clocks after the toggle, far longer
    // than the three system cycles needed to pick it up.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tgl_meta_q <= 1'h0;
            tgl_sync_q <= 1'h0;
            tgl_seen_q <= 1'h0;
        end else begin
            tgl_meta_q <= done_tgl_q;
            tgl_sync_q <= tgl_meta_q;
            tgl_seen_q <= tgl_sync_q;
        end
    end

    // One valid pulse per finished frame; aborted frames never toggle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_q <= '0;
            valid_q  <= 1'h0;
        end else begin
            valid_q <= done_evt;
            if (done_evt) begin
                result_q <= word_q;
            end
        end
    end

    assign powered_o      = ~cs_sync_q; // RQ1
    assign converting_o   = conv_sync_q;
    assign result_o       = result_q;
    assign result_valid_o = valid_q;

endmodule

`default_nettype wire

// ---- core/adc_serial_host.sv ----
// Serial master end: chip select, divided serial clock and result capture
`default_nettype none

module adc_serial_host (
    input  wire logic                              clk_i,
    input  wire logic                              rst_b_i,
    adc_link_if.host                               link,
    input  wire logic                              start_i,
    input  wire logic                              byte_mode_i,
    input  wire logic                              abort_i,
    output logic                                   busy_o,
    output logic [adc_link_pkg::RESULT_W-1:0]      result_o,
    output logic                                   result_valid_o,
    output logic                                   lead_ok_o
);
    import adc_link_pkg::*;

    host_state_t            st_q;
    logic                   cs_b_q;
    logic                   sclk_q;
    logic [WAIT_W-1:0]      ph_q;
    logic [WAIT_W-1:0]      wait_q;
    logic [CNT_W-1:0]       bits_q;
    logic [FRAME_BITS-1:0]  shift_q;
    logic                   pend_q;
    logic                   mode_q;
    logic                   din_meta_q;
    logic                   din_sync_q;
    logic [RESULT_W-1:0]    result_q;
    logic                   valid_q;
    logic                   lead_q;

    logic                   half_end;
    logic                   do_rise;
    logic                   do_fall;
    logic                   capture;
    logic [CNT_W-1:0]       bits_next;
    logic [FRAME_BITS-1:0]  shift_next;
    logic                   frame_end;
    logic                   group_end;
    logic                   stop_req;

    // Clock low while idle; high phase lasts SCLK_HALF_CYC cycles, low phase one cycle more
    assign half_end = (ph_q == HALF_LAST); // RQ12 RQ13
    assign do_rise  = (st_q == H_RUN) && !sclk_q && half_end && !pend_q; // RQ14
    assign do_fall  = (st_q == H_RUN) && sclk_q && half_end;

    // Synchronised data shows the level at the rising edge one cycle
    // after the clock has fallen again, hence the pending flag.
    assign capture    = (st_q == H_RUN) && pend_q && !sclk_q && (ph_q == '0); // RQ9
    assign bits_next  = bits_q + CNT_W'(1);
    assign shift_next = {shift_q[FRAME_BITS-2:0], din_sync_q};
    assign frame_end  = capture && (bits_next == FRAME_CNT); // RQ10
    assign group_end  = capture && mode_q && (bits_next[2:0] == GROUP_CNT[2:0]); // RQ15
    assign stop_req   = abort_i && (st_q != H_IDLE) && (st_q != H_CSHIGH);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            din_meta_q <= 1'h0;
            din_sync_q <= 1'h0;
        end else begin
            din_meta_q <= link.dout_line;
            din_sync_q <= din_meta_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q    <= H_IDLE;
            cs_b_q  <= 1'h1;
            sclk_q  <= 1'h0;
            ph_q    <= '0;
            wait_q  <= '0;
            bits_q  <= '0;
            shift_q <= '0;
            pend_q  <= 1'h0;
            mode_q  <= 1'h0;
        end else if (stop_req) begin
            st_q   <= H_CSHIGH; // RQ11
            cs_b_q <= 1'h1;
            sclk_q <= 1'h0;
            wait_q <= CS_HIGH_LOAD;
        end else begin
            case (st_q)
                H_IDLE: begin
                    if (start_i) begin
                        st_q    <= H_SETUP;
                        cs_b_q  <= 1'h0;
                        mode_q  <= byte_mode_i;
                        bits_q  <= '0;
                        shift_q <= '0;
                        pend_q  <= 1'h0;
                        ph_q    <= '0;
                        wait_q  <= CS_SETUP_LOAD;
                    end
                end
                H_SETUP: begin
                    if (wait_q == '0) begin
                        st_q <= H_RUN;
                    end else begin
                        wait_q <= wait_q - WAIT_W'(1);
                    end
                end
                H_RUN: begin
                    ph_q <= (half_end || capture) ? '0 : ph_q + WAIT_W'(1);
                    if (do_rise) begin
                        sclk_q <= 1'h1;
                        pend_q <= 1'h1;
                    end else if (do_fall) begin
                        sclk_q <= 1'h0;
                    end
                    if (capture) begin
                        pend_q  <= 1'h0;
                        bits_q  <= bits_next;
                        shift_q <= shift_next;
                    end
                    if (frame_end) begin
                        st_q   <= H_CSHIGH; // RQ10
                        cs_b_q <= 1'h1;
                        wait_q <= CS_HIGH_LOAD;
                    end else if (group_end) begin
                        st_q   <= H_GAP; // RQ16
                        wait_q <= GAP_LOAD;
                    end
                end
                H_GAP: begin
                    if (wait_q == '0) begin
                        st_q <= H_RUN;
                        ph_q <= '0;
                    end else begin
                        wait_q <= wait_q - WAIT_W'(1);
                    end
                end
                H_CSHIGH: begin
                    if (wait_q == '0) begin
                        st_q <= H_IDLE; // RQ11
                    end else begin
                        wait_q <= wait_q - WAIT_W'(1);
                    end
                end
                default: begin
                    st_q   <= H_IDLE;
                    cs_b_q <= 1'h1;
                    sclk_q <= 1'h0;
                end
            endcase
        end
    end

    // Result and zero check only for a full frame; aborts leave them
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_q <= '0;
            valid_q  <= 1'h0;
            lead_q   <= 1'h0;
        end else begin
            valid_q <= frame_end && !stop_req;
            if (frame_end && !stop_req) begin
                result_q <= shift_next[RESULT_W-1:0]; // RQ15
                lead_q   <= (shift_next[FRAME_BITS-1:RESULT_W] == '0);
            end
        end
    end

    assign link.cs_b      = cs_b_q;
    assign link.sclk      = sclk_q;
    assign busy_o         = (st_q != H_IDLE);
    assign result_o       = result_q;
    assign result_valid_o = valid_q;
    assign lead_ok_o      = lead_q;

endmodule

`default_nettype wire

// ---- bench/adc_link_asserts.sv ----
// Link checker: select, serial clock and data line timing on the shared link
`default_nettype none

module adc_link_asserts (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic cs_b,
    input  wire logic sclk,
    input  wire logic dout,
    input  wire logic dout_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       sclk_q;
    logic [4:0] falls_q;
    logic [5:0] cur_falls;
    wire        fall_now = sclk_q & ~sclk;

    // Data seen at a sample already reflects a fall that the counter has not taken yet
    assign cur_falls = {1'h0, falls_q} + {5'h00, fall_now};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_q  <= 1'h0;
            falls_q <= 5'h00;
        end else begin
            sclk_q <= sclk;
            if (cs_b) begin
                falls_q <= 5'h00;
            end else if (fall_now && falls_q != 5'h1F) begin
                falls_q <= falls_q + 5'h01;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_select;
        $fell(cs_b);
    endsequence
    sequence s_rise;
        $rose(sclk);
    endsequence
    sequence s_fall;
        $fell(sclk);
    endsequence

    AST_OE_FOLLOWS_SELECT: assert property (dout_oe == !cs_b)
        else $error("data enable differs from select");
    AST_LOW_ON_SELECT: assert property (s_select |-> dout_oe && !dout)
        else $error("data line not low at select");
    AST_SHIFT_ON_FALL: assert property (!cs_b && !$past(cs_b) && $changed(dout) |-> s_fall)
        else $error("data changed away from a clock fall");
    AST_LEAD_ZEROS: assert property (!cs_b && cur_falls < 6'h08 |-> !dout)
        else $error("leading bit not zero");
    AST_TRAIL_ZEROS: assert property (!cs_b && cur_falls >= 6'h18 |-> !dout)
        else $error("trailing bit not zero");
    AST_IDLE_LOW: assert property (cs_b |-> !sclk)
        else $error("serial clock high while deselected");
    AST_SELECT_SETUP: assert property (s_select |-> !sclk [*3])
        else $error("clock rose too soon after select");
    AST_HIGH_PHASE: assert property (s_rise |-> sclk [*2])
        else $error("clock high phase too short");
    AST_LOW_PHASE: assert property (s_fall |-> !sclk [*2])
        else $error("clock low phase too short");
    AST_RATE_FLOOR: assert property (s_rise |-> ##[1:100] s_fall)
        else $error("clock high phase too long");
    AST_SELECT_HIGH_MIN: assert property ($rose(cs_b) |=> cs_b)
        else $error("select high time too short");
endmodule

`default_nettype wire

// ---- bench/test_sar_adc_serial_readout.sv ----
// Bench: host and converter joined, plus a converter driven by hand
`default_nettype none

module test_sar_adc_serial_readout;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_link_pkg::*;

    localparam int DLY = 1;
    // Hand-driven link clock: 64 ns period, no phase tie to clk_i
    localparam int LINK_HALF = 32;
    logic                clk_i = 1'h0;
    logic                rst_b_i = 1'h1;
    logic                start = 1'h0;
    logic                byte_mode = 1'h0;
    logic                abort = 1'h0;
    logic [RESULT_W-1:0] input_code = 16'h0000;
    logic [RESULT_W-1:0] input_code2 = 16'h0000;
    logic                busy, host_valid, lead_ok, powered, converting, dev_valid;
    logic                powered2, converting2, dev2_valid;
    logic [RESULT_W-1:0] host_res, dev_res, dev2_res;
    logic [23:0]         wire_sr = 24'h000000;
    logic [RESULT_W-1:0] host_q[$], dev_q[$], dev2_q[$];
    int                  err_count = 0;
    int                  comparisons = 0;
    int                  seed = 32'h55D0;

    always #50 clk_i = ~clk_i;

    adc_link_if link ();
    adc_link_if link2 ();

    adc_serial_device adc_serial_device_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
        .analog_input_i(input_code), .powered_o(powered), .converting_o(converting),
        .result_o(dev_res), .result_valid_o(dev_valid));
    adc_serial_host adc_serial_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
        .start_i(start), .byte_mode_i(byte_mode), .abort_i(abort), .busy_o(busy),
        .result_o(host_res), .result_valid_o(host_valid), .lead_ok_o(lead_ok));
    // Hand-driven converter, so the bench can break the host's side of the rules
    adc_serial_device adc_serial_device_solo_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link2),
        .analog_input_i(input_code2), .powered_o(powered2), .converting_o(converting2),
        .result_o(dev2_res), .result_valid_o(dev2_valid));
    adc_link_asserts adc_link_asserts_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b(link.cs_b),
        .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe));

    always @(posedge link.sclk) wire_sr <= {wire_sr[22:0], link.dout_line};

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic take(input string what, ref logic [15:0] q[$], input logic [15:0] got);
        if (q.size() == 0) begin
            check({what, " unexpected"}, 24'h000000, 24'h000001);
        end else begin
            check(what, {8'h00, q.pop_front()}, {8'h00, got});
        end
    endtask

    always @(posedge clk_i) begin
        #DLY;
        if (host_valid === 1'h1 && host_q.size() > 0) check("wire", {8'h00, host_q[0]}, wire_sr);
        if (host_valid === 1'h1) check("lead zeros", 24'h000001, {23'h0, lead_ok});
        if (host_valid === 1'h1) take("host result", host_q, host_res);
        if (dev_valid === 1'h1) take("device result", dev_q, dev_res);
        if (dev2_valid === 1'h1) take("hand result", dev2_q, dev2_res);
    end

    task automatic run_frame(input logic [15:0] v, input logic bm, input logic cut);
        int n;
        n = 0;
        @(posedge clk_i);
        #DLY;
        input_code = v;
        byte_mode = bm;
        start = 1'h1;
        if (!cut) begin
            host_q.push_back(v);
            dev_q.push_back(v);
        end
        @(posedge clk_i);
        #DLY;
        start = 1'h0;
        if (cut) begin
            repeat (40) @(posedge clk_i);
            #DLY;
            check("converting", 24'h000001, {23'h0, converting});
            check("powered", 24'h000001, {23'h0, powered});
            abort = 1'h1;
            @(posedge clk_i);
            #DLY;
            abort = 1'h0;
            repeat (6) @(posedge clk_i);
            #DLY;
            check("aborted", 24'h000000, {23'h0, converting});
            check("powered down", 24'h000000, {23'h0, powered});
        end
        while (busy !== 1'h0 && n < 400) begin
            @(posedge clk_i);
            #DLY;
            n++;
        end
        check("frame end", 24'h000000, {23'h0, busy});
        repeat (8) @(posedge clk_i);
        $display("test frame %h mode %0d cut %0d done", v, bm, cut);
    endtask

    task automatic hand_frame(input logic [15:0] v, input int falls);
        logic [23:0] exp;
        exp = {8'h00, v};
        @(posedge clk_i);
        #DLY;
        input_code2 = v;
        link2.cs_b = 1'h0;
        if (falls >= 24) dev2_q.push_back(v);
        @(posedge clk_i);
        #DLY;
        check("select low", 24'h000000, {23'h0, link2.dout_line});
        repeat (2) @(posedge clk_i);
        #DLY;
        check("hand powered", 24'h000001, {23'h0, powered2});
        // Link clock runs only inside the frame and stands low outside it
        for (int i = 0; i < falls; i++) begin
            #LINK_HALF;
            link2.sclk = 1'h1;
            check("hand bit", {23'h0, (i < 24) ? exp[23-i] : 1'h0},
                  {23'h0, link2.dout_line});
            #LINK_HALF;
            link2.sclk = 1'h0;
        end
        @(posedge clk_i);
        #DLY;
        link2.cs_b = 1'h1;
        @(posedge clk_i);
        #DLY;
        check("released", 24'h000000, {23'h0, link2.dout_oe});
        repeat (6) @(posedge clk_i);
        #DLY;
        check("hand idle", 24'h000000, {23'h0, converting2});
        check("hand power down", 24'h000000, {23'h0, powered2});
        $display("test hand frame %h falls %0d done", v, falls);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run is near 1100 cycles; the limit leaves wide margin
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        $display("mismatch watchdog expected finish seen hang");
        close_out();
    end

    initial begin
        // Reset and idle levels land after time zero, so every reset edge is seen
        #DLY;
        rst_b_i = 1'h0;
        link2.cs_b = 1'h1;
        link2.sclk = 1'h0;
        repeat (3) @(posedge clk_i);
        #DLY;
        rst_b_i = 1'h1;
        run_frame(16'h0000, 1'h0, 1'h0);
        run_frame(16'hFFFF, 1'h1, 1'h0);
        run_frame(16'hA5C3, 1'h1, 1'h1);
        run_frame(16'h8001, 1'h0, 1'h0);
        repeat (4) run_frame(16'($random(seed)), 1'($random(seed)), 1'h0);
        hand_frame(16'h5A3C, 10);
        hand_frame(16'($random(seed)), 24);
        hand_frame(16'hC001, 28);
        check("pending", 24'h000000, 24'(host_q.size() + dev_q.size() + dev2_q.size()));
        close_out();
    end
endmodule

`default_nettype wire
